// >>> logic/comparator_control_flags.sv
/*
  Control and status logic around one analog comparator, reached through one
  8-bit special-function register. Assumes a single-cycle SFR bus with write and
  read strobes, and an asynchronous comparator output from the analog core.
*/
// Overview of operation
// RULE_01: Bit 7 high enables the comparator; low disables it.
// RULE_02: Bit 6 reads the comparator output, high when noninverting input is higher.
// RULE_03: Bit 5 latches on every rising output edge until software clears it.
// RULE_04: Bit 4 latches on every falling output edge until software clears it.
// RULE_05: Bits 3 to 2 select positive hysteresis driven to the analog core.
// RULE_06: Bits 1 to 0 select negative hysteresis driven to the analog core.
// RULE_07: Comparator output is synchronised before edge detection, one flag per transition.
`timescale 1ns/1ps
module comparator_control_flags
  import comparator_control_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [comparator_control_pkg::addr_width-1:0] sfr_addr,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [comparator_control_pkg::data_width-1:0] sfr_wdata,
  output logic [comparator_control_pkg::data_width-1:0] sfr_rdata,
  input wire logic comparator_raw_out,
  output logic comparator_enable_bit,
  output logic [comparator_control_pkg::hyst_width-1:0] positive_hysteresis_sel,
  output logic [comparator_control_pkg::hyst_width-1:0] negative_hysteresis_sel
);
  import comparator_control_pkg::*;

  // ****************************************
  // Comparator output synchroniser
  // ****************************************
  logic sync_first;
  logic sync_second;
  logic comparator_output_state;
  logic next_sync_first;
  logic next_sync_second;
  logic next_output_state;

  // RULE_07: Two-stage synchroniser.
  always_comb begin
    next_sync_first = comparator_raw_out;
    next_sync_second = sync_first;
    next_output_state = sync_second;
  end

  // RULE_07: Clears to idle level.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_first <= comparator_zero_control_reset[output_state_pos];
      sync_second <= comparator_zero_control_reset[output_state_pos];
      comparator_output_state <= comparator_zero_control_reset[output_state_pos];
    end else begin
      sync_first <= next_sync_first;
      sync_second <= next_sync_second;
      comparator_output_state <= next_output_state;
    end
  end

  // ****************************************
  // Edge detection
  // ****************************************
  logic rising_seen;
  logic falling_seen;

  // RULE_03: Rising edge detect.
  assign rising_seen = sync_second & ~comparator_output_state;
  // RULE_04: Falling edge detect.
  assign falling_seen = ~sync_second & comparator_output_state;

  // ****************************************
  // Register address decode
  // ****************************************
  logic reg_selected;
  logic hit_write;
  logic hit_read;

  // RULE_01: Register address match.
  assign reg_selected = (sfr_addr == comparator_zero_control_addr);
  assign hit_write = sfr_write & reg_selected;
  assign hit_read = sfr_read & reg_selected;

  // ****************************************
  // Comparator enable
  // ****************************************
  logic next_enable;

  always_comb begin
    next_enable = comparator_enable_bit;
    // RULE_01: Enable bit write.
    if (hit_write) begin
      next_enable = sfr_wdata[enable_bit_pos];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      comparator_enable_bit <= comparator_zero_control_reset[enable_bit_pos];
    end else begin
      comparator_enable_bit <= next_enable;
    end
  end

  // ****************************************
  // Hysteresis selects
  // ****************************************
  hysteresis_t pos_code;
  hysteresis_t neg_code;
  logic [hyst_width-1:0] next_pos;
  logic [hyst_width-1:0] next_neg;

  // RULE_05: Positive hysteresis decode.
  always_comb begin
    case (sfr_wdata[pos_hyst_hi:pos_hyst_lo])
      hyst_2mv: pos_code = hyst_2mv;
      hyst_4mv: pos_code = hyst_4mv;
      hyst_10mv: pos_code = hyst_10mv;
      default: pos_code = hyst_off_t_val;
    endcase
  end

  // RULE_06: Negative hysteresis decode.
  always_comb begin
    case (sfr_wdata[neg_hyst_hi:neg_hyst_lo])
      hyst_2mv: neg_code = hyst_2mv;
      hyst_4mv: neg_code = hyst_4mv;
      hyst_10mv: neg_code = hyst_10mv;
      default: neg_code = hyst_off_t_val;
    endcase
  end

  always_comb begin
    next_pos = positive_hysteresis_sel;
    next_neg = negative_hysteresis_sel;
    if (hit_write) begin
      // RULE_05: Positive select write.
      next_pos = pos_code;
      // RULE_06: Negative select write.
      next_neg = neg_code;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      positive_hysteresis_sel <= comparator_zero_control_reset[pos_hyst_hi:pos_hyst_lo];
      negative_hysteresis_sel <= comparator_zero_control_reset[neg_hyst_hi:neg_hyst_lo];
    end else begin
      positive_hysteresis_sel <= next_pos;
      negative_hysteresis_sel <= next_neg;
    end
  end

  // ****************************************
  // Edge event flags
  // ****************************************
  logic rising_edge_event_flag;
  logic falling_edge_event_flag;
  logic next_rising;
  logic next_falling;

  always_comb begin
    next_rising = rising_edge_event_flag;
    next_falling = falling_edge_event_flag;
    if (hit_write) begin
      // RULE_03: Software flag write.
      next_rising = sfr_wdata[rising_flag_pos];
      // RULE_04: Software flag write.
      next_falling = sfr_wdata[falling_flag_pos];
    end
    // RULE_03: Edge set wins.
    if (rising_seen) begin
      next_rising = 1'h1;
    end
    // RULE_04: Edge set wins.
    if (falling_seen) begin
      next_falling = 1'h1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rising_edge_event_flag <= comparator_zero_control_reset[rising_flag_pos];
      falling_edge_event_flag <= comparator_zero_control_reset[falling_flag_pos];
    end else begin
      rising_edge_event_flag <= next_rising;
      falling_edge_event_flag <= next_falling;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [data_width-1:0] read_word;
  logic [data_width-1:0] next_rdata;

  always_comb begin
    read_word = read_idle_value;
    // RULE_01: Enable readback.
    read_word[enable_bit_pos] = next_enable;
    // RULE_02: Output state readback.
    read_word[output_state_pos] = comparator_output_state;
    // RULE_03: Rising flag readback.
    read_word[rising_flag_pos] = next_rising;
    // RULE_04: Falling flag readback.
    read_word[falling_flag_pos] = next_falling;
    // RULE_05: Positive select readback.
    read_word[pos_hyst_hi:pos_hyst_lo] = next_pos;
    // RULE_06: Negative select readback.
    read_word[neg_hyst_hi:neg_hyst_lo] = next_neg;
  end

  always_comb begin
    next_rdata = read_idle_value;
    if (hit_read) begin
      next_rdata = read_word;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= read_idle_value;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end
endmodule : comparator_control_flags

// >>> logic/comparator_control_pkg.sv
/*
  Constants for the comparator control and status register block.
  Assumes an 8-bit special-function register bus inside the microcontroller core.
*/
package comparator_control_pkg;
  localparam int data_width = 8;
  localparam int addr_width = 8;
  localparam logic [7:0] comparator_zero_control_addr = 8'h9E;
  localparam logic [7:0] comparator_zero_control_reset = 8'h00;
  localparam logic [7:0] read_idle_value = 8'h00;
  localparam int enable_bit_pos = 7;
  localparam int output_state_pos = 6;
  localparam int rising_flag_pos = 5;
  localparam int falling_flag_pos = 4;
  localparam int pos_hyst_hi = 3;
  localparam int pos_hyst_lo = 2;
  localparam int neg_hyst_hi = 1;
  localparam int neg_hyst_lo = 0;
  localparam int hyst_width = 2;
  typedef enum logic [1:0] {
    hyst_off_t_val = 2'h0,
    hyst_2mv = 2'h1,
    hyst_4mv = 2'h2,
    hyst_10mv = 2'h3
  } hysteresis_t;
endpackage : comparator_control_pkg

// >>> sim/comparator_control_flags_tb_top.sv
/* Self-checking testbench for comparator_control_flags. Assumes the package and the checker are compiled first. */
`timescale 1ns/1ps
module comparator_control_flags_tb_top;
  import comparator_control_pkg::*;
  logic core_clk = 0, sys_rst = 1, sfr_write = 0, sfr_read = 0, comparator_raw_out = 0, comparator_enable_bit;
  logic [7:0] sfr_addr = 8'h9E, sfr_wdata = 8'h00, sfr_rdata, rd_val;
  logic [1:0] positive_hysteresis_sel, negative_hysteresis_sel;
  int err_count = 0, n_tests = 0;
  comparator_control_flags uut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_write(sfr_write),
    .sfr_read(sfr_read),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .comparator_raw_out(comparator_raw_out),
    .comparator_enable_bit(comparator_enable_bit),
    .positive_hysteresis_sel(positive_hysteresis_sel),
    .negative_hysteresis_sel(negative_hysteresis_sel)
  );
  initial forever #5 core_clk = ~core_clk;
  task check(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task test_done;
    $display("Checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task wr(logic [7:0] a, logic [7:0] d);
    @(negedge core_clk) sfr_addr = a;
    sfr_wdata = d;
    sfr_write = 1;
    @(negedge core_clk) sfr_write = 0;
  endtask : wr
  task rd(logic [7:0] a);
    @(negedge core_clk) sfr_addr = a;
    sfr_read = 1;
    @(negedge core_clk) sfr_read = 0;
    rd_val = sfr_rdata;
  endtask : rd
  function logic [7:0] outs();
    return {comparator_enable_bit, 3'h0, positive_hysteresis_sel, negative_hysteresis_sel};
  endfunction : outs
  task t_ctrl;
    for (logic [2:0] k = 0; k < 4; k++) begin
      wr(8'h9E, {k[0], 3'h4, k[1:0], ~k[1:0]});
      check("outputs", outs(), {k[0], 3'h0, k[1:0], ~k[1:0]});
      rd(8'h9E);
      check("readback", rd_val, {k[0], 3'h0, k[1:0], ~k[1:0]});
    end
  endtask : t_ctrl
  task t_edge(logic v, logic [7:0] exp);
    @(negedge core_clk) comparator_raw_out = v;
    repeat (4) @(negedge core_clk);
    rd(8'h9E);
    check("flags", rd_val, exp);
  endtask : t_edge
  task t_reset;
    rd(8'h9E);
    check("reset read", rd_val, 8'h00);
    check("reset outputs", outs(), 8'h00);
  endtask : t_reset
  task t_unmapped;
    wr(8'h9F, 8'h00);
    rd(8'h9F);
    check("unmapped read", rd_val, 8'h00);
    check("unmapped write", outs(), 8'h8C);
  endtask : t_unmapped
  task t_set_wins(logic v, logic [7:0] exp);
    @(negedge core_clk) comparator_raw_out = v;
    @(negedge core_clk);
    wr(8'h9E, 8'h8C);
    rd(8'h9E);
    check("set wins", rd_val, exp);
  endtask : t_set_wins
  task t_soft_flags;
    wr(8'h9E, 8'hBC);
    rd(8'h9E);
    check("soft set", rd_val, 8'hFC);
    wr(8'h9E, 8'h8C);
    rd(8'h9E);
    check("soft clear", rd_val, 8'hCC);
  endtask : t_soft_flags
  task t_mid_reset;
    @(negedge core_clk) sys_rst = 1;
    #1 check("async reset", outs(), 8'h00);
    repeat (2) @(negedge core_clk);
    sys_rst = 0;
    t_reset();
  endtask : t_mid_reset
  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 0;
    t_reset();
    t_ctrl();
    t_unmapped();
    t_edge(1, 8'hEC);
    t_edge(0, 8'hBC);
    wr(8'h9E, 8'h8C);
    t_edge(0, 8'h8C);
    t_set_wins(1, 8'hEC);
    t_soft_flags();
    t_set_wins(0, 8'h9C);
    t_mid_reset();
    test_done();
  end
  initial begin
    #20000;
    err_count++;
    test_done();
  end
endmodule : comparator_control_flags_tb_top

// >>> sim/comparator_control_monitor.sv
/* Assertion checker for comparator_control_flags. Assumes it is bound to the block's ports below. */
`timescale 1ns/1ps
module comparator_control_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic comparator_raw_out,
  input wire logic comparator_enable_bit,
  input wire logic [1:0] positive_hysteresis_sel,
  input wire logic [1:0] negative_hysteresis_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire wr = sfr_write && sfr_addr == 8'h9E;
  wire rd = sfr_read && sfr_addr == 8'h9E && !sfr_write;
  wire rd_hit = sfr_read && sfr_addr == 8'h9E;
  wire raw = comparator_raw_out;
  sequence rise_s; !raw && !sfr_write ##1 (raw && !sfr_write) [*6]; endsequence
  sequence fall_s; raw && !sfr_write ##1 (!raw && !sfr_write) [*6]; endsequence
  a_enable_write: assert property (wr |=>
    comparator_enable_bit == $past(sfr_wdata[7])) else $error("enable");
  a_enable_hold: assert property (!wr |=> $stable(comparator_enable_bit)) else $error("enable hold");
  a_pos_hyst: assert property (wr |=> positive_hysteresis_sel == $past(sfr_wdata[3:2])) else $error("pos");
  a_neg_hyst: assert property (wr |=> negative_hysteresis_sel == $past(sfr_wdata[1:0])) else $error("neg");
  a_read_ctrl: assert property (rd |=> sfr_rdata[7] == comparator_enable_bit
    && sfr_rdata[3:0] == {positive_hysteresis_sel, negative_hysteresis_sel}) else $error("read");
  a_read_idle: assert property (!rd_hit |=> sfr_rdata == 8'h00) else $error("idle");
  a_rise_flag: assert property (rise_s ##0 rd |=> sfr_rdata[6] && sfr_rdata[5]) else $error("rise");
  a_fall_flag: assert property (fall_s ##0 rd |=> !sfr_rdata[6] && sfr_rdata[4]) else $error("fall");
endmodule : comparator_control_monitor
bind comparator_control_flags comparator_control_monitor mon (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .sfr_addr(sfr_addr),
  .sfr_write(sfr_write),
  .sfr_read(sfr_read),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .comparator_raw_out(comparator_raw_out),
  .comparator_enable_bit(comparator_enable_bit),
  .positive_hysteresis_sel(positive_hysteresis_sel),
  .negative_hysteresis_sel(negative_hysteresis_sel)
);
